// *** ascc_baud.v ***
`timescale 1ns/1ps
`include "ascc_map.vh"
// one-cycle tick at sixteen times the bit rate
module ascc_baud #(
    parameter DIV_W = 13
) (
    input  wire             aclk,      // module clock
    input  wire             aresetn,   // sync reset, active low
    input  wire             run,       // generator allowed
    input  wire [DIV_W-1:0] divisor,   // divisor value
    output reg              tick16     // oversample enable
);
    reg [DIV_W-1:0] count;

    always @(posedge aclk) begin
        if (!aresetn || !run || divisor == {DIV_W{1'b0}}) begin // [R4]
            count  <= {DIV_W{1'b0}};
            tick16 <= 1'b0;
        end else if (count >= divisor - {{(DIV_W-1){1'b0}}, 1'b1}) begin // [R1]
            count  <= {DIV_W{1'b0}};
            tick16 <= 1'b1;
        end else begin
            count  <= count + {{(DIV_W-1){1'b0}}, 1'b1};
            tick16 <= 1'b0;
        end
    end
endmodule

// *** ascc_core.v ***
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "ascc_map.vh"
// Summary of operation
// [R1] bit rate is module clock over sixteen times the divisor
// [R2] divisor is 13 bits: five high, eight low, up to 8191
// [R3] baud generator idle after reset until tx_on or rx_on first set
// [R4] baud generator stopped while divisor is zero
// [R5] high divisor write is held and applied on low write
// [R6] unmapped or reserved locations ignore writes and read zero
// [R7] loopback detaches rx pin and feeds receiver from transmitter
// [R8] software enables both transmitter and receiver for loopback
// [R9] in loopback, source bit picks internal tx or tx pin line
// [R10] halt_in_wait set stops the block while cpu waits
// [R11] format bit picks eight or nine data bits, one stop
// [R12] wake bit picks idle line or address mark wake-up
// [R13] idle-type bit picks idle count start after start or stop bit
// [R14] parity enable puts parity in msb position and checks it
// [R15] parity odd select: clear even, set odd
// [R16] only external signals are transmit and receive pins
// [R17] wait halts frames and resumes; reset aborts them
// [R18] tx_on enables transmitter and hands it the transmit pin
// [R19] receiver samples sixteen times per bit
module ascc_core (
    input  wire        aclk,      // module clock
    input  wire        aresetn,   // sync reset, active low
    input  wire        cpu_wait,  // processor in wait mode
    input  wire [5:0]  awaddr,    // write address
    input  wire        awvalid,   // write address valid
    output reg         awready,   // write address ready
    input  wire [31:0] wdata,     // write data
    input  wire [3:0]  wstrb,     // write strobes
    input  wire        wvalid,    // write data valid
    output reg         wready,    // write data ready
    output reg  [1:0]  bresp,     // write response
    output reg         bvalid,    // write response valid
    input  wire        bready,    // write response ready
    input  wire [5:0]  araddr,    // read address
    input  wire        arvalid,   // read address valid
    output reg         arready,   // read address ready
    output reg  [31:0] rdata,     // read data
    output reg  [1:0]  rresp,     // read response
    output reg         rvalid,    // read data valid
    input  wire        rready,    // read data ready
    input  wire        rxd,       // serial receive pin
    output reg         txd,       // serial transmit pin
    output reg         irq        // interrupt, active high
);
    // =========================================================
    // registers
    reg [4:0]  div_hi;
    reg [4:0]  div_hi_hold;
    reg [7:0]  div_lo;
    reg [7:0]  cr1;
    reg [7:0]  cr2;
    reg        started;
    reg [`ASCC_EV_W-1:0] istat;
    reg [`ASCC_EV_W-1:0] imask;
    reg        rx_wake_armed;
    reg        tx_bit8;
    reg [7:0]  tx_buf;
    reg        tx_full;
    reg [8:0]  rx_buf;
    reg        rx_full;
    reg        rx_perr;
    reg        rx_ferr;
    reg        idle_seen;
    reg        ev_txdone;
    reg [`ASCC_EV_W-1:1] ev_rx;
    wire [`ASCC_EV_W-1:0] ev = {ev_rx, ev_txdone};

    wire [12:0] divisor = {div_hi, div_lo};
    wire        halted  = cr1[`ASCC_CR1_HALTW] & cpu_wait; // [R10] [R17]
    wire        tick16;
    wire        nine    = cr1[`ASCC_CR1_NINE];
    wire [3:0]  nbits   = nine ? 4'hB : 4'hA;

    ascc_baud #(.DIV_W(13)) u_baud (
        .aclk    (aclk),
        .aresetn (aresetn),
        .run     (started & ~halted), // [R3]
        .divisor (divisor),
        .tick16  (tick16)
    );

    // =========================================================
    // bus write channel
    reg        aw_got;
    reg        w_got;
    reg [5:0]  aw_q;
    reg [31:0] w_q;
    reg [3:0]  ws_q;
    wire       do_wr  = aw_got & w_got & ~bvalid;
    wire [3:0] wr_idx = aw_q[5:2];
    wire       wr_en  = do_wr & ws_q[0];
    wire [`ASCC_EV_W-1:0] clr = (wr_en && wr_idx == `ASCC_IDX_ISTAT) ?
                                w_q[`ASCC_EV_W-1:0] : {`ASCC_EV_W{1'b0}};

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_got  <= 1'b0;
            w_got   <= 1'b0;
            aw_q    <= 6'h00;
            w_q     <= 32'h00000000;
            ws_q    <= 4'h0;
            awready <= 1'b0;
            wready  <= 1'b0;
            bvalid  <= 1'b0;
            bresp   <= 2'h0;
        end else begin
            awready <= ~aw_got & ~awready & awvalid;
            wready  <= ~w_got & ~wready & wvalid;
            if (awvalid && awready) begin
                aw_got <= 1'b1;
                aw_q   <= awaddr;
            end
            if (wvalid && wready) begin
                w_got <= 1'b1;
                w_q   <= wdata;
                ws_q  <= wstrb;
            end
            if (do_wr) begin
                aw_got <= 1'b0;
                w_got  <= 1'b0;
                bvalid <= 1'b1;
                bresp  <= 2'h0;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // =========================================================
    // transmitter
    reg        tx_busy;
    reg [3:0]  tx_phase;
    reg [3:0]  tx_cnt;
    reg [10:0] tx_sh;
    wire       par_in   = nine ? ^tx_buf[7:0] : ^tx_buf[6:0];
    wire       par_bit  = par_in ^ cr1[`ASCC_CR1_PODD]; // [R15]
    wire [8:0] tx_char  = {tx_bit8, tx_buf};
    reg  [8:0] tx_word;

    always @* begin
        tx_word = tx_char;
        if (cr1[`ASCC_CR1_PEN]) begin // [R14]
            if (nine)
                tx_word[8] = par_bit;
            else
                tx_word[7] = par_bit;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin // [R17]
            tx_busy  <= 1'b0;
            tx_phase <= 4'h0;
            tx_cnt   <= 4'h0;
            tx_sh    <= 11'h7FF;
            txd      <= 1'b1;
            ev_txdone <= 1'b0;
        end else begin
            ev_txdone <= 1'b0;
            if (!cr2[`ASCC_CR2_TX_ON]) begin // [R18]
                tx_busy <= 1'b0;
                txd     <= 1'b1;
            end else if (!tx_busy) begin
                txd <= 1'b1;
                if (tx_full && tick16) begin
                    tx_busy  <= 1'b1;
                    tx_phase <= 4'h0;
                    tx_cnt   <= 4'h0;
                    // [R11] stop, data lsb first, start
                    tx_sh    <= nine ? {1'b1, tx_word, 1'b0} : {2'b11, tx_word[7:0], 1'b0};
                end
            end else if (tick16) begin
                txd      <= tx_sh[0]; // [R16]
                tx_phase <= tx_phase + 4'h1;
                if (tx_phase == 4'hF) begin
                    tx_sh  <= {1'b1, tx_sh[10:1]};
                    tx_cnt <= tx_cnt + 4'h1;
                    if (tx_cnt == nbits - 4'h1) begin
                        tx_busy <= 1'b0;
                        ev_txdone <= 1'b1;
                    end
                end
            end
        end
    end

    // =========================================================
    // receiver
    reg        rx_line;
    // [R7] [R9] loop source: internal shift output or the driven pin level
    wire       rx_src = ~cr1[`ASCC_CR1_LOOP] ? rxd :
                        (cr1[`ASCC_CR1_RX_SOURCE_SELECT] ? txd : (tx_busy ? tx_sh[0] : 1'b1));
    reg        rx_busy;
    reg [3:0]  rx_phase;
    reg [3:0]  rx_cnt;
    reg [9:0]  rx_sh;
    reg [3:0]  ones_cnt;
    reg        ones_run;
    reg [8:0]  got_word;
    reg        got_par_ok;

    always @* begin
        got_word = nine ? rx_sh[9:1] : {1'b0, rx_sh[9:2]};
        if (nine)
            got_par_ok = (^got_word[8:0]) == cr1[`ASCC_CR1_PODD]; // [R14]
        else
            got_par_ok = (^got_word[7:0]) == cr1[`ASCC_CR1_PODD];
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            rx_line  <= 1'b1;
            rx_busy  <= 1'b0;
            rx_phase <= 4'h0;
            rx_cnt   <= 4'h0;
            rx_sh    <= 10'h000;
            ones_cnt <= 4'h0;
            ones_run <= 1'b0;
            ev_rx    <= {(`ASCC_EV_W-1){1'b0}};
        end else begin
            ev_rx    <= {(`ASCC_EV_W-1){1'b0}};
            if (tick16)
                rx_line <= rx_src; // [R19]
            if (!cr2[`ASCC_CR2_RX_ON]) begin
                rx_busy  <= 1'b0;
                ones_run <= 1'b0;
            end else if (tick16) begin
                // [R13] count ones toward idle
                if (ones_run && rx_phase == `ASCC_SAMPLE_MID) begin
                    if (!rx_line) begin
                        ones_cnt <= 4'h0;
                    end else if (ones_cnt == nbits - 4'h1) begin
                        ones_cnt <= 4'h0;
                        ones_run <= 1'b0;
                        ev_rx[`ASCC_EV_IDLE] <= 1'b1;
                    end else begin
                        ones_cnt <= ones_cnt + 4'h1;
                    end
                end
                if (!rx_busy) begin
                    rx_phase <= rx_phase + 4'h1;
                    if (!rx_line) begin
                        rx_busy  <= 1'b1;
                        rx_phase <= 4'h1;
                        rx_cnt   <= 4'h0;
                        ones_cnt <= 4'h0;
                        ones_run <= ~cr1[`ASCC_CR1_ILT];
                    end
                end else begin
                    rx_phase <= rx_phase + 4'h1;
                    if (rx_phase == `ASCC_SAMPLE_MID) begin
                        rx_cnt <= rx_cnt + 4'h1;
                        if (rx_cnt == 4'h0 && rx_line) begin
                            rx_busy <= 1'b0; // false start
                        end else if (rx_cnt == nbits - 4'h1) begin
                            rx_busy  <= 1'b0;
                            ones_run <= 1'b1;
                            ev_rx[`ASCC_EV_RXFULL] <= 1'b1;
                            ev_rx[`ASCC_EV_FERR]   <= ~rx_line;
                            ev_rx[`ASCC_EV_PERR]   <= cr1[`ASCC_CR1_PEN] & ~got_par_ok;
                        end else if (rx_cnt != 4'h0) begin
                            rx_sh <= {rx_line, rx_sh[9:1]};
                        end
                    end
                end
            end
        end
    end

    // =========================================================
    // state, wake-up and interrupt
    wire       rx_msb  = nine ? got_word[8] : got_word[7];
    // [R12] armed receiver accepts only on the selected wake condition
    wire       wake_hit = cr1[`ASCC_CR1_WAKE] ? (ev[`ASCC_EV_RXFULL] & rx_msb) :
                                                ev[`ASCC_EV_IDLE];
    wire       accept   = ev[`ASCC_EV_RXFULL] & (~rx_wake_armed | wake_hit);
    wire [`ASCC_EV_W-1:0] next_istat = (istat & ~clr) |
                                       (ev & {`ASCC_EV_W{accept | ~ev[`ASCC_EV_RXFULL]}});

    always @(posedge aclk) begin
        if (!aresetn) begin
            div_hi        <= `ASCC_BDH_RST;
            div_hi_hold   <= `ASCC_BDH_RST;
            div_lo        <= `ASCC_BDL_RST;
            cr1           <= 8'h00;
            cr2           <= 8'h00;
            started       <= 1'b0;
            istat         <= {`ASCC_EV_W{1'b0}};
            imask         <= {`ASCC_EV_W{1'b0}};
            rx_wake_armed <= 1'b0;
            tx_bit8       <= 1'b0;
            tx_buf        <= 8'h00;
            tx_full       <= 1'b0;
            rx_buf        <= 9'h000;
            rx_full       <= 1'b0;
            rx_perr       <= 1'b0;
            rx_ferr       <= 1'b0;
            idle_seen     <= 1'b0;
            irq           <= 1'b0;
        end else begin
            if (cr2[`ASCC_CR2_TX_ON] || cr2[`ASCC_CR2_RX_ON])
                started <= 1'b1; // [R3]
            if (tx_busy && tx_phase == 4'h0 && tx_cnt == 4'h0)
                tx_full <= 1'b0;
            if (wake_hit)
                rx_wake_armed <= 1'b0;
            if (accept) begin
                rx_buf  <= got_word;
                rx_full <= 1'b1;
                rx_perr <= ev[`ASCC_EV_PERR];
                rx_ferr <= ev[`ASCC_EV_FERR];
            end
            if (ev[`ASCC_EV_IDLE])
                idle_seen <= 1'b1;
            if (wr_en) begin // [R6] only the indices listed below, plus the istat clear, take a write
                case (wr_idx)
                    `ASCC_IDX_BDH:   div_hi_hold <= w_q[4:0]; // [R5]
                    `ASCC_IDX_BDL: begin
                        div_lo <= w_q[7:0]; // [R2]
                        div_hi <= div_hi_hold; // [R5]
                    end
                    `ASCC_IDX_CR1:   cr1 <= w_q[7:0];
                    `ASCC_IDX_CR2:   cr2 <= w_q[7:0];
                    `ASCC_IDX_DRH:   tx_bit8 <= w_q[6];
                    `ASCC_IDX_DRL: begin
                        tx_buf  <= w_q[7:0];
                        tx_full <= 1'b1;
                    end
                    `ASCC_IDX_IMASK: imask <= w_q[`ASCC_EV_W-1:0];
                    `ASCC_IDX_CTRL: begin
                        rx_wake_armed <= w_q[0];
                        rx_full       <= (rx_full & ~w_q[1]) | accept;
                        idle_seen     <= (idle_seen & ~w_q[2]) | ev[`ASCC_EV_IDLE];
                    end
                    default: ;
                endcase
            end
            // set wins over a same-cycle clear
            istat <= next_istat;
            irq   <= |(next_istat & imask);
        end
    end

    // =========================================================
    // bus read channel
    reg [31:0] rd_val;
    wire [3:0] rd_idx = araddr[5:2];

    always @* begin
        rd_val = 32'h00000000; // [R6]
        case (rd_idx)
            `ASCC_IDX_BDH:   rd_val[4:0] = div_hi;
            `ASCC_IDX_BDL:   rd_val[7:0] = div_lo;
            `ASCC_IDX_CR1:   rd_val[7:0] = cr1;
            `ASCC_IDX_CR2:   rd_val[7:0] = cr2;
            `ASCC_IDX_SR1:   rd_val[7:0] = {~tx_full, ~tx_full & ~tx_busy, rx_full,
                                            idle_seen, 1'b0, 1'b0, rx_ferr, rx_perr};
            `ASCC_IDX_DRH:   rd_val[7:6] = {rx_buf[8], tx_bit8};
            `ASCC_IDX_DRL:   rd_val[7:0] = rx_buf[7:0];
            `ASCC_IDX_ISTAT: rd_val[`ASCC_EV_W-1:0] = istat;
            `ASCC_IDX_IMASK: rd_val[`ASCC_EV_W-1:0] = imask;
            `ASCC_IDX_CTRL:  rd_val[0] = rx_wake_armed;
            default:         rd_val = 32'h00000000;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h00000000;
            rresp   <= 2'h0;
        end else begin
            arready <= ~arready & ~rvalid & arvalid;
            if (arvalid && arready) begin
                rvalid <= 1'b1;
                rdata  <= rd_val;
                rresp  <= 2'h0;
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
            end
        end
    end
endmodule

// *** ascc_core_sva.sv ***
`timescale 1ns/1ps
// ==========================================
// port-level checks of the register bus and serial pin
module ascc_core_sva (
    input wire        aclk,    // module clock
    input wire        aresetn, // sync reset, active low
    input wire        awready, // write address ready
    input wire        wvalid,  // write data valid
    input wire        wready,  // write data ready
    input wire [1:0]  bresp,   // write response
    input wire        bvalid,  // write response valid
    input wire        bready,  // write response ready
    input wire        arvalid, // read address valid
    input wire        arready, // read address ready
    input wire [31:0] rdata,   // read data
    input wire [1:0]  rresp,   // read response
    input wire        rvalid,  // read data valid
    input wire        rready,  // read data ready
    input wire        txd,     // serial transmit pin
    input wire        irq      // interrupt
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // reset must be visible, so this one is never disabled
    a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=> txd && !irq && !bvalid && !rvalid)
        else $error("outputs not idle after reset");
    a_read_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read answer late");
    a_ar_cause: assert property ($rose(arready) |-> $past(arvalid))
        else $error("arready without request");
    a_aw_pulse: assert property (awready |=> !awready)
        else $error("awready longer than one cycle");
    a_w_ready_valid: assert property (wready |-> wvalid)
        else $error("wready without wvalid");
    a_b_stands: assert property (bvalid && !bready |=> bvalid)
        else $error("bvalid dropped early");
    a_r_stands: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read answer not held");
    a_resp_okay: assert property (1'b1 |-> (!bvalid || bresp == 2'h0) && (!rvalid || rresp == 2'h0))
        else $error("response not okay");
    // divisor is at least one, so a start bit spans sixteen clocks or more
    a_start_width: assert property ($fell(txd) |-> !txd [*8] ##1 !txd [*8])
        else $error("start bit too short");
    c_write: cover property (bvalid && bready);
    c_read: cover property (rvalid && rready);
    c_frame: cover property ($fell(txd));
    c_irq: cover property ($rose(irq));
endmodule
bind ascc_core ascc_core_sva CHK (.aclk(aclk), .aresetn(aresetn), .awready(awready),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .txd(txd), .irq(irq));

// *** ascc_map.vh ***
`ifndef ASCC_MAP_VH
`define ASCC_MAP_VH
// register indices; byte address is four times the index
`define ASCC_IDX_BDH       4'h0
`define ASCC_IDX_BDL       4'h1
`define ASCC_IDX_CR1       4'h2
`define ASCC_IDX_CR2       4'h3
`define ASCC_IDX_SR1       4'h4
`define ASCC_IDX_SR2       4'h5
`define ASCC_IDX_DRH       4'h6
`define ASCC_IDX_DRL       4'h7
`define ASCC_IDX_ISTAT     4'h8
`define ASCC_IDX_IMASK     4'h9
`define ASCC_IDX_CTRL      4'hA
`define ASCC_ADDR_BITS     6
// reset values
`define ASCC_BDH_RST       5'h00
`define ASCC_BDL_RST       8'h04
// frame_control_one fields
`define ASCC_CR1_LOOP      7
`define ASCC_CR1_HALTW     6
`define ASCC_CR1_RX_SOURCE_SELECT      5
`define ASCC_CR1_NINE      4
`define ASCC_CR1_WAKE      3
`define ASCC_CR1_ILT       2
`define ASCC_CR1_PEN       1
`define ASCC_CR1_PODD      0
// frame_control_two fields
`define ASCC_CR2_TX_ON     3
`define ASCC_CR2_RX_ON     2
// sticky event bits
`define ASCC_EV_TXDONE     0
`define ASCC_EV_RXFULL     1
`define ASCC_EV_PERR       2
`define ASCC_EV_FERR       3
`define ASCC_EV_IDLE       4
`define ASCC_EV_W          5
// oversampling factor
`define ASCC_OVERSAMPLE    16
`define ASCC_SAMPLE_MID    4'h7
`endif

// *** ascc_peer.sv ***
`timescale 1ns/1ps
// ==========================================
// far-side serial station, lsb first, line idles high
module ascc_peer #(
    parameter BIT_CLKS = 32
) (
    input  wire  aclk, // module clock
    input  wire  txd,  // line from the block
    input  wire  jam,  // hold the receive line low
    output logic rxd   // line into the block
);
    logic drv = 1'b1;
    assign rxd = jam ? 1'b0 : drv;
    task send(input [7:0] d);
        integer i;
        begin
            @(posedge aclk);
            drv <= 1'b0;
            repeat (BIT_CLKS) @(posedge aclk);
            for (i = 0; i < 8; i++) begin
                drv <= d[i];
                repeat (BIT_CLKS) @(posedge aclk);
            end
            drv <= 1'b1;
            repeat (BIT_CLKS) @(posedge aclk);
        end
    endtask
    // samples at bit centres; a stalled line gives up after a bounded wait
    task capture(output [7:0] d, output stop_ok);
        integer i;
        integer n;
        begin
            n = 0;
            while (txd !== 1'b0 && n < 5000) begin
                @(posedge aclk);
                n++;
            end
            repeat (BIT_CLKS / 2) @(posedge aclk);
            for (i = 0; i < 8; i++) begin
                repeat (BIT_CLKS) @(posedge aclk);
                d[i] = txd;
            end
            repeat (BIT_CLKS) @(posedge aclk);
            stop_ok = txd;
        end
    endtask
endmodule

// *** async_serial_config_core_tb_top.sv ***
`timescale 1ns/1ps
`include "ascc_map.vh"
module async_serial_config_core_tb_top;
    logic aclk = 0, aresetn = 0, cpu_wait = 0, jam = 0;
    logic [5:0] awaddr = 0, araddr = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = 0;
    logic [3:0] wstrb = 4'hF;
    wire awready, wready, bvalid, arready, rvalid, rxd, txd, irq;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    integer mismatches = 0, check_count = 0;
    // rows: index, written value, value read back
    logic [19:0] rows [0:4] = '{{4'h2, 8'h1D, 8'h1D}, {4'h9, 8'h1F, 8'h1F},
        {4'hB, 8'hFF, 8'h00}, {4'h5, 8'hFF, 8'h00}, {4'h1, 8'h06, 8'h06}};
    // frame_control_one, char, char seen on the wire
    logic [23:0] txt [0:3] = '{{8'h00, 8'hA5, 8'hA5}, {8'h02, 8'h07, 8'h87},
        {8'h03, 8'h03, 8'h83}, {8'h02, 8'h03, 8'h03}};
    ascc_core DUT (.aclk(aclk), .aresetn(aresetn), .cpu_wait(cpu_wait), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .rxd(rxd), .txd(txd), .irq(irq));
    ascc_peer #(.BIT_CLKS(32)) PEER (.aclk(aclk), .txd(txd), .jam(jam), .rxd(rxd));
    initial begin
        forever #50 aclk = ~aclk;
    end
    // ==========================================
    // shared tasks
    task check(input [31:0] seen, input [31:0] exp);
        begin
            check_count++;
            if (seen !== exp) begin
                $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
                mismatches++;
            end
        end
    endtask
    task print_verdict;
        begin
            $display("checks %0d mismatches %0d", check_count, mismatches);
            if (mismatches == 0 && check_count > 0) $display("All tests passed");
            else $display("Some tests failed");
            $finish;
        end
    endtask
    task axi_write(input [3:0] idx, input [7:0] d);
        integer n;
        begin
            @(posedge aclk);
            awaddr <= {idx, 2'b00};
            wdata <= {24'h0, d};
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            n = 0;
            do begin
                @(posedge aclk);
                n++;
                if (awready === 1'b1) awvalid <= 1'b0;
                if (wready === 1'b1) wvalid <= 1'b0;
            end while (bvalid !== 1'b1 && n < 200);
            bready <= 1'b0;
            if (n >= 200) mismatches++;
        end
    endtask
    task axi_read(input [3:0] idx, output [31:0] d);
        integer n;
        begin
            @(posedge aclk);
            araddr <= {idx, 2'b00};
            arvalid <= 1'b1;
            rready <= 1'b1;
            n = 0;
            do begin
                @(posedge aclk);
                n++;
                if (arready === 1'b1) arvalid <= 1'b0;
            end while (rvalid !== 1'b1 && n < 200);
            d = rdata;
            rready <= 1'b0;
            if (n >= 200) mismatches++;
        end
    endtask
    // polls the sticky event register; a frame is well inside the bound
    task wait_ev(input integer b);
        reg [31:0] v;
        integer n;
        begin
            n = 0;
            v = 0;
            while (v[b] !== 1'b1 && n < 300) begin
                axi_read(`ASCC_IDX_ISTAT, v);
                n++;
            end
            check(v[b], 1);
        end
    endtask
    initial begin
        repeat (40000) @(posedge aclk);
        mismatches++;
        print_verdict;
    end
    // ==========================================
    // main sequence
    initial begin
        reg [31:0] v;
        reg [7:0] g;
        reg s;
        integer i;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        for (i = 0; i < 5; i++) begin
            axi_write(rows[i][19:16], rows[i][15:8]);
            axi_read(rows[i][19:16], v);
            check(v, {24'h0, rows[i][7:0]});
        end
        $display("register rows done");
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(`ASCC_IDX_BDH, v);
        check(v, 32'h0);
        axi_read(`ASCC_IDX_BDL, v);
        check(v, 32'h4);
        axi_write(`ASCC_IDX_BDH, 8'h01);
        axi_read(`ASCC_IDX_BDH, v);
        check(v, 32'h0);
        axi_write(`ASCC_IDX_BDL, 8'h02);
        axi_read(`ASCC_IDX_BDH, v);
        check(v, 32'h1);
        axi_write(`ASCC_IDX_BDH, 8'h00);
        axi_write(`ASCC_IDX_BDL, 8'h02);
        $display("reset and divisor done");
        axi_write(`ASCC_IDX_CR2, 8'h0C);
        for (i = 0; i < 4; i++) begin
            axi_write(`ASCC_IDX_CR1, txt[i][23:16]);
            fork
                PEER.capture(g, s);
                axi_write(`ASCC_IDX_DRL, txt[i][15:8]);
            join
            check(g, txt[i][7:0]);
            check(s, 1);
            wait_ev(`ASCC_EV_TXDONE);
            axi_write(`ASCC_IDX_IMASK, {7'h0, i[0]});
            @(posedge aclk);
            check(irq, i[0]);
            axi_write(`ASCC_IDX_ISTAT, 8'h01);
            axi_read(`ASCC_IDX_ISTAT, v);
            check(v[0], 0);
            check(irq, 0);
        end
        // halted in wait: the queued character must not leave until wait ends
        axi_write(`ASCC_IDX_CR1, 8'h40);
        cpu_wait <= 1'b1;
        axi_write(`ASCC_IDX_DRL, 8'h5A);
        repeat (200) @(posedge aclk);
        check(txd, 1);
        fork
            PEER.capture(g, s);
            cpu_wait <= 1'b0;
        join
        check(g, 8'h5A);
        $display("transmit frames done");
        axi_write(`ASCC_IDX_CR1, 8'h00);
        axi_write(`ASCC_IDX_ISTAT, 8'h1F);
        PEER.send(8'h3C);
        wait_ev(`ASCC_EV_RXFULL);
        axi_read(`ASCC_IDX_DRL, v);
        check(v[7:0], 8'h3C);
        wait_ev(`ASCC_EV_IDLE);
        axi_write(`ASCC_IDX_CR1, 8'h02);
        axi_write(`ASCC_IDX_ISTAT, 8'h1F);
        PEER.send(8'h83);
        wait_ev(`ASCC_EV_PERR);
        // armed for address mark: a character without msb set is dropped
        axi_write(`ASCC_IDX_CR1, 8'h08);
        axi_write(`ASCC_IDX_ISTAT, 8'h1F);
        axi_write(`ASCC_IDX_CTRL, 8'h01);
        PEER.send(8'h11);
        axi_read(`ASCC_IDX_ISTAT, v);
        check(v[`ASCC_EV_RXFULL], 0);
        PEER.send(8'h92);
        wait_ev(`ASCC_EV_RXFULL);
        axi_read(`ASCC_IDX_DRL, v);
        check(v[7:0], 8'h92);
        $display("receive frames done");
        // rx pin held low: anything the receiver gets must come from the transmit side
        for (i = 0; i < 2; i++) begin
            axi_write(`ASCC_IDX_CR1, i ? 8'hA0 : 8'h80);
            jam <= 1'b1;
            axi_write(`ASCC_IDX_ISTAT, 8'h1F);
            axi_write(`ASCC_IDX_DRL, 8'h96 ^ i[7:0]);
            wait_ev(`ASCC_EV_RXFULL);
            axi_read(`ASCC_IDX_DRL, v);
            check(v[7:0], 8'h96 ^ i[7:0]);
        end
        $display("loop modes done");
        print_verdict;
    end
endmodule
